// ---- verilog/hrp_top.sv ----
/*
  host register port with diagnostics: direct addresses, index
  pointer, diagnostic and port control, frame signature, pixel
  masking and comparator sense pin.
  assumes: host strobes are single-cycle on ref_clk; vblank, odd field
  and comparator results arrive asynchronously from pins.
*/
// Function
// - set mask bit passes four pixel bits
// - 24-bit feedback signature over one frame
// - armed run cleared by vblank, then starts
// - vblank ends accumulation regardless of run bit
// - interlaced signature starts on odd field
// - sense pin ANDs latched or unlatched bits
// - register_select decodes the direct addresses
// - six-bit palette data shifted two places
// - eight-bit palette data passes unchanged
// - pixel mask ANDs palette index bits in indirect mode
// - read address or access state readback
// - index low and high form one index
// - auto increment after indexed data access
// - cleared run bit disarms before the run starts; a started run ends at vblank
// - masking enable applies, not on legacy port
// - sense pin undriven when disable set
// - port width picks 32 or 64 inputs, not on legacy port
`timescale 1ns/10ps
module hrp_top (
  input  wire logic        ref_clk,             // 25 MHz clock
  input  wire logic        sys_rst,             // async reset, high
  input  wire logic [2:0]  register_select,     // direct address
  input  wire logic        host_wr,             // write strobe
  input  wire logic        host_rd,             // read strobe
  input  wire logic [7:0]  host_wdata,          // write data
  output logic      [7:0]  host_rdata_ff,       // read data
  output logic             host_rvalid_ff,      // read data valid
  output logic             pal_we_ff,           // palette write
  output logic      [7:0]  pal_waddr_ff,        // palette write addr
  output logic      [7:0]  pal_wdata_ff,        // palette write data
  output logic             pal_re,              // palette read
  output logic      [7:0]  pal_raddr_ff,        // palette read addr
  input  wire logic [7:0]  pal_rdata,           // palette data, +1 cyc
  input  wire logic        color_resolution_bit,// 1 = eight-bit data
  input  wire logic        legacy_port_sel,     // eight-bit port on
  input  wire logic        indirect_mode,       // palette lookup mode
  input  wire logic        interlace_mode,      // interlaced timing
  input  wire logic        vblank_pin,          // vertical blanking
  input  wire logic        odd_field_pin,       // odd field flag
  input  wire logic [2:0]  sense_unlatched_pin, // comparator, live
  input  wire logic [2:0]  sense_latched_pin,   // comparator, held
  input  wire logic [63:0] pixel_inputs,        // pixel port
  output logic      [63:0] pixel_masked_ff,     // masked pixel data
  input  wire logic [7:0]  palette_index_in,    // index to palettes
  output logic      [7:0]  palette_index_ff,    // masked index
  input  wire logic [23:0] dac_data,            // data at converters
  output logic      [23:0] signature_ff,        // signature value
  output logic             sense_out_ff,        // sense pin level
  output logic             sense_oe             // sense pin enable
);

  // control registers
  logic [7:0]  pal_addr_ff;        // palette pointer
  logic [1:0]  palette_access_mode_report_ff;       // last address write mode
  logic [7:0]  pix_mask_ff;        // pixel mask
  logic [15:0] index_ff;           // combined internal index
  logic [7:0]  idx_ctrl_ff;        // index stepping control
  logic [7:0]  misc1_ff;           // diagnostic and port control
  logic [15:0] vmask_ff;           // pixel port mask pair
  logic        run_prev_ff;        // run bit one cycle back

  // read pipeline
  logic        rd_pend_ff;         // read in flight
  logic [2:0]  rd_rs_ff;           // address of read
  logic [15:0] rd_idx_ff;          // index of read

  // synchroniser chain and filtered levels
  localparam int ASYNC_W_L = hrp_pkg::ASYNC_W;
  logic [ASYNC_W_L-1:0] s1_ff, s2_ff, s3_ff, lvl_ff;
  // pins gathered in the order the filtered levels are read back
  wire  [ASYNC_W_L-1:0] async_in = {sense_latched_pin,
                                    sense_unlatched_pin,
                                    odd_field_pin,
                                    vblank_pin};
  logic        vb_prev_ff;         // vblank one cycle back

  hrp_pkg::hrp_sig_state_t st_ff, nxt_st;

  // decoded strobes
  wire wr_pal_waddr = host_wr && register_select == hrp_pkg::RS_PAL_WADDR;
  wire wr_pal_data  = host_wr && register_select == hrp_pkg::RS_PAL_DATA;
  wire wr_pix_mask  = host_wr && register_select == hrp_pkg::RS_PIX_MASK;
  wire wr_pal_raddr = host_wr && register_select == hrp_pkg::RS_PAL_RADDR;
  wire wr_idx_low   = host_wr && register_select == hrp_pkg::RS_IDX_LOW;
  wire wr_idx_high  = host_wr && register_select == hrp_pkg::RS_IDX_HIGH;
  wire wr_idx_ctrl  = host_wr && register_select == hrp_pkg::RS_IDX_CTRL;
  wire acc_idx_data = (host_wr || host_rd) &&
                      register_select == hrp_pkg::RS_IDX_DATA;
  wire wr_idx_data  = host_wr && acc_idx_data;
  wire acc_pal_data = (host_wr || host_rd) &&
                      register_select == hrp_pkg::RS_PAL_DATA;
  wire auto_inc     = idx_ctrl_ff[hrp_pkg::IC_AUTO_INC];
  wire wr_misc1     = wr_idx_data && index_ff == hrp_pkg::IDX_MISC1;
  wire wr_vmask_lo  = wr_idx_data && index_ff == hrp_pkg::IDX_VMASK_LO;
  wire wr_vmask_hi  = wr_idx_data && index_ff == hrp_pkg::IDX_VMASK_HI;
  wire mem_we       = wr_idx_data && index_ff[15:8] == hrp_pkg::IDX_MEM_TOP;

  // filtered pin levels
  wire       vb       = lvl_ff[0];
  wire       odd      = lvl_ff[1];
  wire [2:0] sns_live = lvl_ff[4:2];
  wire [2:0] sns_held = lvl_ff[7:5];
  wire       vb_rise  = vb && !vb_prev_ff;
  wire       vb_fall  = !vb && vb_prev_ff;
  wire       run_bit  = misc1_ff[hrp_pkg::MC1_SIG_RUN];
  wire       run_rise = run_bit && !run_prev_ff;

  // sense register image: and of each group above its bits
  wire [7:0] sense_reg = {&sns_held, sns_held, &sns_live, sns_live};

  // palette read is issued straight from the strobe
  assign pal_re = host_rd && register_select == hrp_pkg::RS_PAL_DATA;

  // sense pin driver enable
  assign sense_oe = !misc1_ff[hrp_pkg::MC1_SENSE_DIS];

  // three-flop synchronisers; only the second and third are compared
  genvar gi;
  generate
    for (gi = 0; gi < ASYNC_W_L; gi++) begin : g_sync
      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          s1_ff[gi]  <= 1'b0;
          s2_ff[gi]  <= 1'b0;
          s3_ff[gi]  <= 1'b0;
          lvl_ff[gi] <= 1'b0;
        end else begin
          s1_ff[gi] <= async_in[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          // change accepted once second and third agree
          if (s2_ff[gi] == s3_ff[gi]) begin
            lvl_ff[gi] <= s3_ff[gi];
          end
        end
      end
    end
  endgenerate

  // palette pointer, access state and pixel mask
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pal_addr_ff  <= 8'h00;
      palette_access_mode_report_ff <= hrp_pkg::ACC_WRITE;
      pix_mask_ff  <= hrp_pkg::PIX_MASK_RESET;
    end else begin
      if (wr_pal_waddr) begin
        pal_addr_ff  <= host_wdata;
        palette_access_mode_report_ff <= hrp_pkg::ACC_WRITE;
      end else if (wr_pal_raddr) begin
        pal_addr_ff  <= host_wdata;
        palette_access_mode_report_ff <= hrp_pkg::ACC_READ;
      end else if (acc_pal_data) begin
        pal_addr_ff  <= pal_addr_ff + 8'h01;  // step to next entry
      end
      if (wr_pix_mask) begin
        pix_mask_ff <= host_wdata;
      end
    end
  end

  // palette write port, registered; format follows resolution
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pal_we_ff    <= 1'b0;
      pal_waddr_ff <= 8'h00;
      pal_wdata_ff <= 8'h00;
    end else begin
      pal_we_ff    <= wr_pal_data;
      pal_waddr_ff <= pal_addr_ff;
      if (color_resolution_bit) begin
        pal_wdata_ff <= host_wdata;
      end else begin
        pal_wdata_ff <= {host_wdata[5:0], 2'b00};
      end
    end
  end

  // read address output tracks the pointer
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pal_raddr_ff <= 8'h00;
    end else begin
      pal_raddr_ff <= pal_addr_ff;
    end
  end

  // index pointer: low and high halves, stepping after data access
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      index_ff    <= 16'h0000;
      idx_ctrl_ff <= 8'h00;
    end else begin
      if (wr_idx_low) begin
        index_ff[7:0] <= host_wdata;
      end else if (wr_idx_high) begin
        index_ff[15:8] <= host_wdata;
      end else if (acc_idx_data && auto_inc) begin
        index_ff <= index_ff + 16'h0001;  // wraps past top
      end
      if (wr_idx_ctrl) begin
        idx_ctrl_ff <= {7'h00, host_wdata[hrp_pkg::IC_AUTO_INC]};
      end
    end
  end

  // diagnostic and port control, and mask pair
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      misc1_ff    <= hrp_pkg::MC1_RESET;
      vmask_ff    <= hrp_pkg::VMASK_RESET;
      run_prev_ff <= 1'b0;
    end else begin
      if (wr_misc1) begin
        misc1_ff <= host_wdata & hrp_pkg::MC1_WMASK;
      end
      if (wr_vmask_lo) begin
        vmask_ff[7:0] <= host_wdata;
      end
      if (wr_vmask_hi) begin
        vmask_ff[15:8] <= host_wdata;
      end
      run_prev_ff <= run_bit;
    end
  end

  // indexed space beyond the dedicated locations
  logic [7:0] mem_rdata;   // one cycle after request
  hrp_mem u_mem (
    .ref_clk  (ref_clk),
    .we       (mem_we),
    .addr     (index_ff[7:0]),
    .wdata    (host_wdata),
    .rdata_ff (mem_rdata)
  );

  // indexed read selection, from the index captured with the read
  wire [7:0] idx_rd =
    (rd_idx_ff == hrp_pkg::IDX_MISC1)    ? misc1_ff :
    (rd_idx_ff == hrp_pkg::IDX_VMASK_LO) ? vmask_ff[7:0] :
    (rd_idx_ff == hrp_pkg::IDX_VMASK_HI) ? vmask_ff[15:8] :
    (rd_idx_ff == hrp_pkg::IDX_SIG_0)    ? signature_ff[7:0] :
    (rd_idx_ff == hrp_pkg::IDX_SIG_1)    ? signature_ff[15:8] :
    (rd_idx_ff == hrp_pkg::IDX_SIG_2)    ? signature_ff[23:16] :
    (rd_idx_ff == hrp_pkg::IDX_SENSE)    ? sense_reg :
    (rd_idx_ff[15:8] == hrp_pkg::IDX_MEM_TOP) ? mem_rdata : 8'h00;

  // palette data and read pointer readback formats
  wire [7:0] pal_rd = color_resolution_bit ? pal_rdata :
                      {2'b00, pal_rdata[7:2]};
  wire [7:0] raddr_rd = misc1_ff[hrp_pkg::MC1_RFMT] ?
                        {6'h00, palette_access_mode_report_ff} : pal_addr_ff;

  // direct address read selection
  wire [7:0] rd_mux =
    (rd_rs_ff == hrp_pkg::RS_PAL_WADDR) ? pal_addr_ff :
    (rd_rs_ff == hrp_pkg::RS_PAL_DATA)  ? pal_rd :
    (rd_rs_ff == hrp_pkg::RS_PIX_MASK)  ? pix_mask_ff :
    (rd_rs_ff == hrp_pkg::RS_PAL_RADDR) ? raddr_rd :
    (rd_rs_ff == hrp_pkg::RS_IDX_LOW)   ? index_ff[7:0] :
    (rd_rs_ff == hrp_pkg::RS_IDX_HIGH)  ? index_ff[15:8] :
    (rd_rs_ff == hrp_pkg::RS_IDX_DATA)  ? idx_rd : idx_ctrl_ff;

  // two-stage read: memory and palette answer one cycle late
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_pend_ff     <= 1'b0;
      rd_rs_ff       <= 3'h0;
      rd_idx_ff      <= 16'h0000;
      host_rdata_ff  <= 8'h00;
      host_rvalid_ff <= 1'b0;
    end else begin
      rd_pend_ff     <= host_rd;
      rd_rs_ff       <= register_select;
      rd_idx_ff      <= index_ff;
      host_rvalid_ff <= rd_pend_ff;
      if (rd_pend_ff) begin
        host_rdata_ff <= rd_mux;
      end
    end
  end

  // signature sequencer; run bit arms, and cleared before the run disarms; vblank times everything
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      hrp_pkg::SIG_IDLE: begin
        if (run_rise) nxt_st = hrp_pkg::SIG_ARMED;
      end
      hrp_pkg::SIG_ARMED: begin
        if (!run_bit) nxt_st = hrp_pkg::SIG_IDLE;
        else if (vb_rise) nxt_st = hrp_pkg::SIG_WAIT;
      end
      hrp_pkg::SIG_WAIT: begin
        // interlaced frames must open on the odd field
        if (!run_bit) nxt_st = hrp_pkg::SIG_IDLE;
        else if (vb_fall && (!interlace_mode || odd))
          nxt_st = hrp_pkg::SIG_RUN;
      end
      hrp_pkg::SIG_RUN: begin
        if (vb_rise) begin
          // interlace needs both fields before the frame ends
          if (!interlace_mode || !odd) nxt_st = hrp_pkg::SIG_DONE;
        end
      end
      hrp_pkg::SIG_DONE: begin
        if (run_rise) nxt_st = hrp_pkg::SIG_ARMED;
      end
      default: nxt_st = hrp_pkg::SIG_IDLE;
    endcase
  end

  // feedback shift of the signature with data folded in
  wire        fb       = ^(signature_ff & hrp_pkg::SIG_TAPS);
  wire [23:0] misr_nxt = {signature_ff[22:0], fb} ^ dac_data;

  // state and signature registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff        <= hrp_pkg::SIG_IDLE;
      signature_ff <= hrp_pkg::SIG_RESET;
      vb_prev_ff   <= 1'b0;
    end else begin
      st_ff      <= nxt_st;
      vb_prev_ff <= vb;
      if (st_ff == hrp_pkg::SIG_ARMED && vb_rise) begin
        signature_ff <= hrp_pkg::SIG_RESET;
      end else if (st_ff == hrp_pkg::SIG_RUN && !vb) begin
        signature_ff <= misr_nxt;
      end
    end
  end

  // pixel masking: each mask bit governs a nibble of the port
  logic [63:0] pix_keep;   // per-bit pass enables
  generate
    for (gi = 0; gi < 16; gi++) begin : g_mask
      // legacy port disables both masking and width selection
      assign pix_keep[gi*4 +: 4] = {4{
        (legacy_port_sel || !misc1_ff[hrp_pkg::MC1_MASK_EN] ||
         vmask_ff[gi]) &&
        (legacy_port_sel || gi < 8 || misc1_ff[hrp_pkg::MC1_WIDTH])}};
    end
  endgenerate

  // registered data path outputs and sense pin level
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pixel_masked_ff  <= 64'h0000_0000_0000_0000;
      palette_index_ff <= 8'h00;
      sense_out_ff     <= 1'b0;
    end else begin
      pixel_masked_ff  <= pixel_inputs & pix_keep;
      palette_index_ff <= indirect_mode ?
                          (palette_index_in & pix_mask_ff) :
                          palette_index_in;
      sense_out_ff     <= misc1_ff[hrp_pkg::MC1_SENSE_SEL] ?
                          sense_reg[7] : sense_reg[3];
    end
  end

  // checks
  sequence arm_s;
    run_rise && st_ff == hrp_pkg::SIG_IDLE;
  endsequence
  sequence clear_s;
    st_ff == hrp_pkg::SIG_ARMED && vb_rise && run_bit;
  endsequence

  arm_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clear_s |=> signature_ff == hrp_pkg::SIG_RESET &&
                st_ff == hrp_pkg::SIG_WAIT)
    else $error("signature not cleared at vblank");
  arm_enter_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    arm_s |=> st_ff == hrp_pkg::SIG_ARMED)
    else $error("run bit rise did not arm");
  sig_step_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_ff == hrp_pkg::SIG_RUN && !vb |=> signature_ff == $past(misr_nxt))
    else $error("signature did not accumulate");
  sig_stop_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_ff == hrp_pkg::SIG_RUN && vb_rise && !interlace_mode
      |=> st_ff == hrp_pkg::SIG_DONE ##1 $stable(signature_ff))
    else $error("signature kept running past vblank");
  odd_start_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_ff == hrp_pkg::SIG_WAIT && interlace_mode && !odd && run_bit
      |=> st_ff != hrp_pkg::SIG_RUN)
    else $error("interlaced run started on even field");
  sense_pin_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ##1 sense_out_ff == ($past(misc1_ff[hrp_pkg::MC1_SENSE_SEL]) ?
                         $past(&sns_held) : $past(&sns_live)))
    else $error("sense pin level wrong");
  mask_wr_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_pix_mask |=> pix_mask_ff == $past(host_wdata))
    else $error("pixel mask write lost");
  pal_fmt_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_pal_data && !color_resolution_bit |=>
      pal_we_ff && pal_wdata_ff == {$past(host_wdata[5:0]), 2'b00})
    else $error("six-bit palette write misformatted");
  rfmt_rd_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    host_rd && register_select == hrp_pkg::RS_PAL_RADDR &&
    misc1_ff[hrp_pkg::MC1_RFMT] && !host_wr
      |=> ##1 host_rvalid_ff && host_rdata_ff[7:2] == 6'h00)
    else $error("access state readback wrong");
  idx_step_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    acc_idx_data && auto_inc |=> index_ff == $past(index_ff) + 16'h0001)
    else $error("index did not step");
  sense_oe_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    misc1_ff[hrp_pkg::MC1_SENSE_DIS] |-> !sense_oe)
    else $error("sense pin driven while disabled");
  width_cut_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !legacy_port_sel && !misc1_ff[hrp_pkg::MC1_WIDTH]
      |=> pixel_masked_ff[63:32] == 32'h0000_0000)
    else $error("upper pixel half not ignored");
  nib_mask_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !legacy_port_sel && misc1_ff[hrp_pkg::MC1_MASK_EN] && !vmask_ff[0]
      |=> pixel_masked_ff[3:0] == 4'h0)
    else $error("masked nibble not zeroed");

endmodule

// ---- verilog/hrp_pkg.sv ----
/*
  constants for the host register port and diagnostics block:
  direct address codes, indexed locations, control bit positions,
  reset values and signature feedback taps.
  assumes: included before every module of the block.
*/
package hrp_pkg;

  // direct addresses on register_select
  localparam logic [2:0] RS_PAL_WADDR = 3'h0;
  localparam logic [2:0] RS_PAL_DATA  = 3'h1;
  localparam logic [2:0] RS_PIX_MASK  = 3'h2;
  localparam logic [2:0] RS_PAL_RADDR = 3'h3;
  localparam logic [2:0] RS_IDX_LOW   = 3'h4;
  localparam logic [2:0] RS_IDX_HIGH  = 3'h5;
  localparam logic [2:0] RS_IDX_DATA  = 3'h6;
  localparam logic [2:0] RS_IDX_CTRL  = 3'h7;

  // indexed locations
  localparam logic [15:0] IDX_MISC1    = 16'h0070;
  localparam logic [15:0] IDX_VMASK_LO = 16'h0078;
  localparam logic [15:0] IDX_VMASK_HI = 16'h0079;
  localparam logic [15:0] IDX_SIG_0    = 16'h007a;
  localparam logic [15:0] IDX_SIG_1    = 16'h007b;
  localparam logic [15:0] IDX_SIG_2    = 16'h007c;
  localparam logic [15:0] IDX_SENSE    = 16'h007d;
  localparam logic [7:0]  IDX_MEM_TOP  = 8'h00;   // index high for memory

  // diagnostic and port control fields
  localparam int MC1_SIG_RUN   = 7;
  localparam int MC1_MASK_EN   = 6;
  localparam int MC1_RFMT      = 5;
  localparam int MC1_SENSE_DIS = 4;
  localparam int MC1_SENSE_SEL = 3;
  localparam int MC1_WIDTH     = 0;
  localparam logic [7:0] MC1_RESET = 8'h00;
  localparam logic [7:0] MC1_WMASK = 8'hf9;      // bits 2:1 reserved

  // index control field
  localparam int IC_AUTO_INC = 0;

  // palette access state codes
  localparam logic [1:0] ACC_WRITE = 2'h0;
  localparam logic [1:0] ACC_READ  = 2'h3;

  // reset values
  localparam logic [7:0]  PIX_MASK_RESET = 8'hff;
  localparam logic [15:0] VMASK_RESET    = 16'hffff;
  localparam logic [23:0] SIG_RESET      = 24'h00_0000;
  localparam logic [23:0] SIG_TAPS       = 24'he1_0000;

  // async pin synchroniser width: vblank, odd, 3 unlatched, 3 latched
  localparam int ASYNC_W = 8;

  typedef enum logic [2:0] {
    SIG_IDLE, SIG_ARMED, SIG_WAIT, SIG_RUN, SIG_DONE
  } hrp_sig_state_t;

endpackage

// ---- verilog/hrp_mem.sv ----
/*
  small single port memory for the indexed register space.
  read data leaves through a register, one cycle after the request.
  assumes: one clock, write and read never in the same cycle.
*/
`timescale 1ns/10ps
module hrp_mem (
  input  wire logic       ref_clk,   // block clock
  input  wire logic       we,        // write strobe
  input  wire logic [7:0] addr,      // entry address
  input  wire logic [7:0] wdata,     // write data
  output logic      [7:0] rdata_ff   // registered read data
);

  logic [7:0] mem [0:255];           // storage, no reset by design

  // plain synchronous ram; contents stay undefined until written
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_ff <= mem[addr];
  end

endmodule

// ---- dv/hrp_host_model.sv ----
/*
  host processor model: one-cycle write and read strobes on the
  eight-address register bus.
  assumes: reads answered by host_rvalid_ff two edges after the strobe.
*/
`timescale 1ns/10ps
module hrp_host_model (
  input  wire logic       ref_clk,         // block clock
  output logic      [2:0] register_select, // direct address
  output logic            host_wr,         // write strobe
  output logic            host_rd,         // read strobe
  output logic      [7:0] host_wdata,      // write data
  input  wire logic [7:0] host_rdata_ff,   // read data
  input  wire logic       host_rvalid_ff   // read answer
);
  initial begin
    register_select = 3'h0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 8'h00;
  end
  // released data is inverted so a stale byte never looks valid
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    register_select <= a;
    host_wdata <= v;
    host_wr <= 1'b1;
    @(posedge ref_clk);
    host_wr <= 1'b0;
    host_wdata <= ~v;
  endtask
  // answer taken at the edge where valid is seen high, bounded wait
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    int n;
    @(posedge ref_clk);
    register_select <= a;
    host_rd <= 1'b1;
    @(posedge ref_clk);
    host_rd <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (host_rvalid_ff !== 1'b1 && n < 8);
    v = host_rdata_ff;
  endtask
endmodule

// ---- dv/tb.sv ----
/*
  self-checking bench for the host register port.
  assumes: host model drives the bus; bench drives pins and pixels.
*/
`timescale 1ns/10ps
module tb;
  logic ref_clk=0, sys_rst=1, host_wr, host_rd, host_rvalid_ff, pal_we_ff;
  logic pal_re, color_resolution_bit=0, legacy_port_sel=0, indirect_mode=0;
  logic interlace_mode=0, vblank_pin=0, odd_field_pin=0, sense_out_ff;
  logic sense_oe;
  logic [2:0]  register_select, sense_unlatched_pin=0, sense_latched_pin=0;
  logic [7:0]  host_wdata, host_rdata_ff, pal_waddr_ff, pal_wdata_ff, d, m;
  logic [7:0]  pal_raddr_ff, pal_rdata=0, palette_index_in=0;
  logic [7:0]  palette_index_ff, c;
  logic [63:0] pixel_inputs=0, pixel_masked_ff;
  logic [23:0] dac_data=0, signature_ff, s;
  logic [15:0] vm;
  logic [31:0] rng = 32'h0000_0228;
  int mismatches, checked;
  hrp_top i_hrp_top (.*);
  hrp_host_model h (.*);
  always #20 ref_clk = ~ref_clk;
  // xorshift source, fixed start
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // nibble n passes when its mask bit is set and the port is wide enough
  function automatic logic [63:0] vexp(logic [63:0] p, logic [15:0] k,
                                       logic w);
    for (int n = 0; n < 16; n++)
      if (!k[n] || (n > 7 && !w)) p[4*n+:4] = 4'h0;
    return p;
  endfunction
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic iwr(logic [7:0] i, logic [7:0] v);
    h.wr(3'h4, i);
    h.wr(3'h6, v);
  endtask
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge ref_clk);
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    h.wr(3'h4, 8'h70);
    h.rd(3'h6, d);
    chk("ctrl_rst", d, hrp_pkg::MC1_RESET);
    h.rd(3'h2, d);
    chk("mask_rst", d, hrp_pkg::PIX_MASK_RESET);
    iwr(8'h70, 8'hff);
    h.rd(3'h6, d);
    chk("ctrl_rsv", d, hrp_pkg::MC1_WMASK);
    // indexed writes back to back, read back by stepping
    h.wr(3'h5, 8'h00);
    h.wr(3'h7, 8'h01);
    h.wr(3'h4, 8'h10);
    s = xs();
    for (int i = 0; i < 3; i++) h.wr(3'h6, s[8*i+:8]);
    h.wr(3'h4, 8'h10);
    for (int i = 0; i < 3; i++) begin
      h.rd(3'h6, d);
      chk("auto_inc", d, s[8*i+:8]);
    end
    $display("test index done");
    for (int k = 0; k < 2; k++) begin
      color_resolution_bit <= k[0];
      d = xs();
      h.wr(3'h0, 8'h20);
      h.wr(3'h1, d);
      #1 chk("pal_wd", pal_wdata_ff, k ? d : {d[5:0], 2'b00});
      m = xs();
      pal_rdata <= m;
      h.wr(3'h3, 8'h40);
      h.rd(3'h1, c);
      chk("pal_rd", c, k ? m : {2'b00, m[7:2]});
    end
    iwr(8'h70, 8'h20);
    h.rd(3'h3, d);
    chk("acc_rd", d, 8'h03);
    h.wr(3'h0, 8'h00);
    h.rd(3'h3, d);
    chk("acc_wr", d, 8'h00);
    indirect_mode <= 1'b1;
    m = xs();
    h.wr(3'h2, m);
    d = xs();
    palette_index_in <= d;
    repeat (3) @(posedge ref_clk);
    chk("pidx", palette_index_ff, d & m);
    $display("test palette done");
    for (int k = 0; k < 3; k++) begin
      vm = xs();
      iwr(8'h78, vm[7:0]);
      iwr(8'h79, vm[15:8]);
      legacy_port_sel <= (k == 2);
      iwr(8'h70, 8'h40 | k[0]);
      pixel_inputs <= {xs(), xs()};
      repeat (3) @(posedge ref_clk);
      chk("pix", pixel_masked_ff, vexp(pixel_inputs,
          (k == 2) ? 16'hffff : vm, k != 0));
    end
    legacy_port_sel <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      iwr(8'h70, k[7:0] << 3);
      sense_unlatched_pin <= (k == 0) ? 3'h7 : xs();
      sense_latched_pin <= (k == 1) ? 3'h7 : xs();
      repeat (8) @(posedge ref_clk);
      chk("sense", sense_out_ff, k[0] ? &sense_latched_pin
          : &sense_unlatched_pin);
      chk("sense_oe", sense_oe, !k[1]);
    end
    $display("test diag done");
    iwr(8'h70, 8'h00);
    iwr(8'h70, 8'h80);
    vblank_pin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("sig_clr", signature_ff, hrp_pkg::SIG_RESET);
    vblank_pin <= 1'b0;
    repeat (40) @(posedge ref_clk) dac_data <= xs();
    vblank_pin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    s = signature_ff;
    chk("sig_run", s != 24'h00_0000, 1'b1);
    repeat (20) @(posedge ref_clk) dac_data <= xs();
    chk("sig_hold", signature_ff, s);
    h.wr(3'h4, 8'h7a);
    for (int i = 0; i < 3; i++) begin
      h.rd(3'h6, d);
      chk("sig_rd", d, s[8*i+:8]);
    end
    iwr(8'h70, 8'h80);
    vblank_pin <= 1'b0;
    repeat (30) @(posedge ref_clk) dac_data <= xs();
    vblank_pin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("sig_rearm", signature_ff, s);
    // interlaced: the even field passes while armed, before the clear; the odd field after it starts the run
    interlace_mode <= 1'b1;
    iwr(8'h70, 8'h00);
    iwr(8'h70, 8'h80);
    repeat (8) @(posedge ref_clk);
    vblank_pin <= 1'b0;
    repeat (20) @(posedge ref_clk) dac_data <= xs();
    vblank_pin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("sig_even", signature_ff, 24'h00_0000);
    odd_field_pin <= 1'b1;
    vblank_pin <= 1'b0;
    repeat (20) @(posedge ref_clk) dac_data <= xs();
    chk("sig_odd", signature_ff != 24'h00_0000, 1'b1);
    $display("test signature done");
    give_verdict();
  end
endmodule
